// ---- hold_timer.sv ----
/*
  persistence timer: done rises after run has stayed high for limit
  consecutive cycles, and clears at once when run falls.
  assumes limit is at least one.
*/
module hold_timer (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [ocp_pkg::TMR_W-1:0] limit,
  output logic done
);

  logic [ocp_pkg::TMR_W-1:0] cnt_r; // cycles seen with run high

  // ------------------------------------------------------------
  // count; any drop restarts the qualification from zero
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !run) begin
      cnt_r <= '0;
      done <= 1'b0;
    end else if (!done) begin
      if (cnt_r == limit - ocp_pkg::TMR_W'(1)) begin
        done <= 1'b1;
      end else begin
        cnt_r <= cnt_r + ocp_pkg::TMR_W'(1);
      end
    end
  end

endmodule // hold_timer

// ---- ocp_guard.sv ----
/*
  over-current protection, lockout gating, frequency register and
  current monitor capture of a multiphase buck controller, with a
  classic wishbone register slave and one level interrupt.
  assumes the analog comparators and supply monitors arrive as async
  levels and the internal converter delivers codes with a valid strobe
  on ref_clk.
*/

module ocp_guard #(
  parameter int LIM100_CYCLES = ocp_pkg::LIM100_CYC,
  parameter int MS_CYCLES = ocp_pkg::MS_CYC,
  parameter int ADC_REF_MV = 2500
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // analog levels
  input wire ocp_pkg::pins_type pins_in,
  // converter results
  input wire logic ocsel_valid,
  input wire logic [3:0] ocsel_code,
  input wire logic [7:0] freq_pin_code,
  input wire logic imon_valid,
  input wire logic [7:0] imon_code,
  // controls
  output logic ocsel_source_en,
  output logic [7:0] phase_thr_mv,
  output logic [7:0] freq_cfg,
  output logic softstart_go,
  output logic drive_enable,
  output logic fault_latched,
  output logic irq
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  localparam int IMON_MAX_I = ocp_pkg::IMON_FS_MV * ocp_pkg::ADC_MAX
                              / ADC_REF_MV;
  localparam logic [7:0] IMON_MAX_CODE = 8'(IMON_MAX_I); // 2 V code

  ocp_pkg::pins_type pins; // filtered levels
  ocp_pkg::state_type state_r, state_nxt;
  ocp_pkg::ocp_sel_type strap_sel_r; // decoded at startup
  ocp_pkg::ocp_sel_type reg_sel_r; // software setting
  ocp_pkg::ocp_sel_type eff_sel; // setting in use
  logic ovr_en_r; // software setting wins
  logic [7:0] imon_r; // last monitor sample
  logic imon_max_r; // sample at full system current
  logic [ocp_pkg::N_EV-1:0] status_r;
  logic [ocp_pkg::N_EV-1:0] mask_r;
  logic [ocp_pkg::N_EV-1:0] events;
  logic lim100_done; // qualified timed trip
  logic [ocp_pkg::N_PHASE-1:0] phase_run;
  logic [ocp_pkg::N_PHASE-1:0] phase_done;
  logic [ocp_pkg::TMR_W-1:0] dly_cyc; // selected delay in cycles
  logic supplies_ok;
  logic trip;
  logic run;
  logic acc; // request being answered this cycle
  logic wr_acc;
  logic rd_acc;

  // ------------------------------------------------------------
  // input conditioning
  // ------------------------------------------------------------
  sync3 #(
    .W($bits(ocp_pkg::pins_type))
  ) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .din(pins_in),
    .dout(pins)
  );

  assign supplies_ok = pins.vcc_ok && pins.ramp_ok;
  assign run = (state_r == ocp_pkg::ST_RUN);

  // ------------------------------------------------------------
  // total current limit qualification
  // ------------------------------------------------------------
  // short excursions restart the count inside the timer
  hold_timer u_lim100 (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .run(pins.lim100 && run),
    .limit(ocp_pkg::TMR_W'(LIM100_CYCLES)),
    .done(lim100_done)
  );

  // ------------------------------------------------------------
  // per-phase latch-off timers
  // ------------------------------------------------------------
  assign eff_sel = ovr_en_r ? reg_sel_r : strap_sel_r;
  assign dly_cyc = ocp_pkg::TMR_W'(ocp_pkg::dly_ms(eff_sel.dly) * MS_CYCLES);

  genvar g;
  generate
    for (g = 0; g < ocp_pkg::N_PHASE; g++) begin : g_phase
      assign phase_run[g] = pins.phase_over[g] && run;
      hold_timer u_ph (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .run(phase_run[g]),
        .limit(dly_cyc),
        .done(phase_done[g])
      );
    end
  endgenerate

  // 150% comparator bypasses any qualification
  assign trip = pins.lim150 || lim100_done || (|phase_done);

  // ------------------------------------------------------------
  // sequencing state machine
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ocp_pkg::ST_UVLO: begin
        // wait for enable and both supply monitors
        if (pins.enable && supplies_ok) begin
          state_nxt = ocp_pkg::ST_SELECT;
        end
      end
      ocp_pkg::ST_SELECT: begin
        if (!pins.enable || !supplies_ok) begin
          state_nxt = ocp_pkg::ST_UVLO;
        end else if (ocsel_valid) begin
          state_nxt = ocp_pkg::ST_RUN;
        end
      end
      ocp_pkg::ST_RUN: begin
        // a trip wins over a supply drop so the fault is remembered
        if (trip) begin
          state_nxt = ocp_pkg::ST_LATCHED;
        end else if (!pins.enable || !supplies_ok) begin
          state_nxt = ocp_pkg::ST_UVLO;
        end
      end
      ocp_pkg::ST_LATCHED: begin
        // no retry: only a low enable releases the latch
        if (!pins.enable) begin
          state_nxt = ocp_pkg::ST_UVLO;
        end
      end
      default: state_nxt = ocp_pkg::ST_UVLO;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_r <= ocp_pkg::ST_UVLO;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------
  // startup capture of strap selection; the frequency pin is loaded in the frequency register block
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      strap_sel_r <= ocp_pkg::SEL_RST;
    end else if (state_r == ocp_pkg::ST_SELECT && ocsel_valid) begin
      strap_sel_r <= ocsel_code;
    end
  end

  // ------------------------------------------------------------
  // outputs toward the analog side
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ocsel_source_en <= 1'b0;
      phase_thr_mv <= ocp_pkg::THR0_MV;
      softstart_go <= 1'b0;
      drive_enable <= 1'b0;
      fault_latched <= 1'b0;
    end else begin
      ocsel_source_en <= (state_nxt == ocp_pkg::ST_SELECT);
      phase_thr_mv <= ocp_pkg::thr_mv(eff_sel.thr);
      softstart_go <= (state_nxt == ocp_pkg::ST_RUN);
      drive_enable <= (state_nxt == ocp_pkg::ST_RUN);
      fault_latched <= (state_nxt == ocp_pkg::ST_LATCHED);
    end
  end

  // ------------------------------------------------------------
  // current monitor capture
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      imon_r <= 8'h00;
      imon_max_r <= 1'b0;
    end else if (imon_valid) begin
      imon_r <= imon_code;
      imon_max_r <= (imon_code >= IMON_MAX_CODE);
    end
  end

  // ------------------------------------------------------------
  // wishbone slave: one wait state, ack for a single cycle
  // ------------------------------------------------------------
  assign acc = wb_cyc_i && wb_stb_i && wb_ack_o;
  assign wr_acc = acc && wb_we_i;
  assign rd_acc = acc && !wb_we_i;

  // ack rises one cycle after the request, falls the next cycle
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // read data latched with ack; unmapped addresses read as zero
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      wb_dat_o <= 32'h0000_0000;
      unique case (wb_adr_i)
        ocp_pkg::ADR_PHASE_OCP: begin
          wb_dat_o[3:0] <= eff_sel;
          wb_dat_o[ocp_pkg::OCP_OVR_BIT] <= ovr_en_r;
        end
        ocp_pkg::ADR_FREQ: wb_dat_o[7:0] <= freq_cfg;
        ocp_pkg::ADR_IMON: begin
          wb_dat_o[7:0] <= imon_r;
          wb_dat_o[ocp_pkg::IMON_MAX_BIT] <= imon_max_r;
        end
        ocp_pkg::ADR_STATUS: wb_dat_o[3:0] <= status_r;
        ocp_pkg::ADR_MASK: wb_dat_o[3:0] <= mask_r;
        ocp_pkg::ADR_STATE: wb_dat_o[3:0] <= state_r;
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // software setting of the per-phase protection
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_sel_r <= ocp_pkg::SEL_RST;
      ovr_en_r <= 1'b0;
    end else if (wr_acc && wb_adr_i == ocp_pkg::ADR_PHASE_OCP) begin
      if (wb_sel_i[0]) begin
        reg_sel_r <= wb_dat_i[3:0];
      end
      if (wb_sel_i[1]) begin
        ovr_en_r <= wb_dat_i[ocp_pkg::OCP_OVR_BIT];
      end
    end
  end

  // frequency register: loaded from the pin at startup, then writable
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      freq_cfg <= ocp_pkg::FREQ_RST;
    end else if (wr_acc && wb_adr_i == ocp_pkg::ADR_FREQ && wb_sel_i[0]) begin
      freq_cfg <= wb_dat_i[7:0];
    end else if (state_r == ocp_pkg::ST_SELECT && ocsel_valid) begin
      freq_cfg <= freq_pin_code;
    end
  end

  // interrupt mask
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      mask_r <= ocp_pkg::MASK_RST;
    end else if (wr_acc && wb_adr_i == ocp_pkg::ADR_MASK && wb_sel_i[0]) begin
      mask_r <= wb_dat_i[3:0];
    end
  end

  // ------------------------------------------------------------
  // sticky events; a new event in the clearing read survives
  // ------------------------------------------------------------
  always_comb begin
    events = '0;
    events[ocp_pkg::EV_LIM100] = lim100_done && run;
    events[ocp_pkg::EV_LIM150] = pins.lim150 && run;
    events[ocp_pkg::EV_PHASE] = (|phase_done) && run;
    events[ocp_pkg::EV_READY] = state_r == ocp_pkg::ST_SELECT &&
                                state_nxt == ocp_pkg::ST_RUN;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      status_r <= '0;
    end else if (rd_acc && wb_adr_i == ocp_pkg::ADR_STATUS) begin
      // clear only what the read reported: a bit set while the read
      // waited for ack has not been seen yet and must stay
      status_r <= (status_r & ~wb_dat_o[ocp_pkg::N_EV-1:0]) | events;
    end else begin
      status_r <= status_r | events;
    end
  end

  assign irq = |(status_r & mask_r);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_run_over150;
    run && pins.lim150;
  endsequence

  sequence s_latched_off;
    state_r == ocp_pkg::ST_LATCHED ##1 !drive_enable;
  endsequence

  a_lim150_instant: assert property (s_run_over150 |=> s_latched_off)
    else $error("150 percent limit did not latch off");
  a_lim100_drop: assert property (!pins.lim100 |=> !lim100_done)
    else $error("timed limit fired without a continuous excursion");
  a_trip_latch: assert property (run && trip |=> s_latched_off)
    else $error("trip did not shut outputs");
  a_latch_holds: assert property (
    state_r == ocp_pkg::ST_LATCHED && pins.enable |=>
    state_r == ocp_pkg::ST_LATCHED && !drive_enable)
    else $error("latch released while enable high");
  a_select_source: assert property (
    state_r == ocp_pkg::ST_SELECT && ocsel_valid |=>
    strap_sel_r == $past(ocsel_code) && !ocsel_source_en)
    else $error("startup selection not captured");
  a_thr_decode: assert property (
    $stable(eff_sel) [*2] |-> phase_thr_mv == ocp_pkg::thr_mv(eff_sel.thr))
    else $error("threshold output does not match selection");
  a_override_sel: assert property (
    ovr_en_r && $past(ovr_en_r) && $stable(reg_sel_r) |->
    phase_thr_mv == ocp_pkg::thr_mv(reg_sel_r.thr))
    else $error("override setting not in use");
  a_softstart_gate: assert property (
    softstart_go |-> $past(pins.vcc_ok) && $past(pins.ramp_ok))
    else $error("soft start without both supplies");
  a_freq_write: assert property (
    wr_acc && wb_adr_i == ocp_pkg::ADR_FREQ && wb_sel_i[0] |=>
    freq_cfg == $past(wb_dat_i[7:0]))
    else $error("frequency write lost");
  a_imon_capture: assert property (
    imon_valid |=> imon_r == $past(imon_code) &&
    imon_max_r == ($past(imon_code) >= IMON_MAX_CODE))
    else $error("monitor sample not captured");
  a_phase_restart: assert property (
    (phase_done & ~$past(phase_run)) == '0)
    else $error("phase timer survived a drop below threshold");

endmodule // ocp_guard

// ---- ocp_guard_tb.sv ----
/*
  self-checking bench for ocp_guard: startup, selection, bus registers,
  monitor capture, the three trip paths, latch-off and the interrupt.
  assumes ocp_pkg is compiled first; short counts via parameters.
*/
module ocp_guard_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0; // 100 MHz
  logic reset_n = 1'b0; // sync, active low
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, src_en, go, drv, flt, irq;
  logic [7:0] thr, fcfg;
  ocp_pkg::pins_type pins = '0; // all levels low
  logic ocv = 1'b0, imv = 1'b0;
  logic [3:0] occ = 4'h0;
  logic [7:0] fpin = 8'h00, imc = 8'h00;
  logic [31:0] q; // last read word
  int error_cnt = 0;
  int comparisons = 0;
  // expected thresholds by index; kept local so no design code is reused
  logic [7:0] thr_t [4] = '{8'h41, 8'h4B, 8'h64, 8'h86};

  always #5 ref_clk = ~ref_clk;

  // short counts: 20 cycles for the timed limit, 10 cycles per ms
  ocp_guard #(.LIM100_CYCLES(20), .MS_CYCLES(10)) DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pins_in(pins),
    .ocsel_valid(ocv), .ocsel_code(occ), .freq_pin_code(fpin),
    .imon_valid(imv), .imon_code(imc), .ocsel_source_en(src_en),
    .phase_thr_mv(thr), .freq_cfg(fcfg), .softstart_go(go),
    .drive_enable(drv), .fault_latched(flt), .irq(irq));

  // ----------------------------------------------------------------
  // common tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic stop_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one classic cycle; held until ack is sampled, then released
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do @(posedge ref_clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // supplies and enable up, select, then code accepted into run
  task automatic start(input logic [3:0] c, input logic [7:0] f);
    pins.enable <= 1'b1;
    pins.vcc_ok <= 1'b1;
    pins.ramp_ok <= 1'b1;
    cyc_n(8);
    chk("src_en", 1, src_en);
    chk("drive pre", 0, drv);
    occ <= c;
    fpin <= f;
    ocv <= 1'b1;
    @(posedge ref_clk);
    ocv <= 1'b0;
    cyc_n(2);
    chk("drive", 1, drv);
    chk("soft", 1, go);
    chk("thr", thr_t[c[1:0]], thr);
    chk("freq pin", f, fcfg);
    wb(0, ocp_pkg::ADR_STATUS, 0); // drop the ready event
  endtask

  // leave latch-off by dropping enable
  task automatic stop_en;
    pins.enable <= 1'b0;
    cyc_n(8);
    chk("unlatched", 0, flt);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset;
    chk("thr rst", 8'h41, thr);
    chk("irq rst", 0, irq);
    wb(0, ocp_pkg::ADR_MASK, 0);
    chk("mask rst", 0, q);
    wb(1, 8'h40, 32'hFF);
    wb(0, 8'h40, 0);
    chk("unmapped", 0, q);
    // controller supply good but ramp supply low: stay locked out
    pins.enable <= 1'b1;
    pins.vcc_ok <= 1'b1;
    cyc_n(12);
    chk("lockout", 0, src_en);
  endtask

  task automatic s_cfg;
    start(4'h6, 8'h5A);
    wb(1, ocp_pkg::ADR_FREQ, 32'h33);
    @(posedge ref_clk);
    chk("freq wr", 8'h33, fcfg);
    wb(1, ocp_pkg::ADR_PHASE_OCP, 32'h103);
    cyc_n(2);
    chk("ovr thr", 8'h86, thr);
    wb(0, ocp_pkg::ADR_PHASE_OCP, 0);
    chk("ovr rd", 32'h103, q);
    for (int i = 0; i < 2; i++) begin
      imc <= 8'hCC - 8'(i);
      imv <= 1'b1;
      @(posedge ref_clk);
      imv <= 1'b0;
      wb(0, ocp_pkg::ADR_IMON, 0);
      chk("imon", i ? 32'h0CB : 32'h1CC, q);
    end
    wb(1, ocp_pkg::ADR_PHASE_OCP, 32'h0);
    stop_en();
  endtask

  // phase 3 over threshold: 40 cycle delay, a drop restarts it
  task automatic s_phase;
    start(4'h1, 8'h11);
    pins.phase_over[3] <= 1'b1;
    cyc_n(30);
    pins.phase_over[3] <= 1'b0;
    cyc_n(10);
    pins.phase_over[3] <= 1'b1;
    cyc_n(30);
    chk("ph early", 0, flt);
    cyc_n(30);
    chk("ph trip", 1, flt);
    chk("ph drv", 0, drv);
    pins.phase_over[3] <= 1'b0;
    wb(0, ocp_pkg::ADR_STATUS, 0);
    chk("ph st", 32'h4, q);
    stop_en();
  endtask

  // short excursion ignored, long one trips; masked: no interrupt
  task automatic s_lim100;
    start(4'h0, 8'h22);
    pins.lim100 <= 1'b1;
    cyc_n(12);
    pins.lim100 <= 1'b0;
    cyc_n(30);
    chk("l100 short", 0, flt);
    pins.lim100 <= 1'b1;
    cyc_n(40);
    chk("l100 trip", 1, flt);
    chk("masked", 0, irq);
    pins.lim100 <= 1'b0;
    wb(0, ocp_pkg::ADR_STATUS, 0);
    chk("l100 st", 32'h1, q);
    stop_en();
  endtask

  task automatic s_lim150;
    wb(1, ocp_pkg::ADR_MASK, 32'h2);
    start(4'hF, 8'h44);
    pins.lim150 <= 1'b1;
    cyc_n(7);
    chk("l150 trip", 1, flt);
    chk("l150 soft", 0, go);
    chk("irq", 1, irq);
    pins.lim150 <= 1'b0;
    cyc_n(20);
    chk("stays", 1, flt);
    wb(0, ocp_pkg::ADR_STATUS, 0);
    chk("l150 st", 32'h2, q);
    @(posedge ref_clk);
    chk("irq clr", 0, irq);
    wb(0, ocp_pkg::ADR_STATE, 0);
    chk("latched", 32'h8, q);
    stop_en();
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    cyc_n(20);
    reset_n <= 1'b1;
    s_reset();
    s_cfg();
    s_phase();
    s_lim100();
    s_lim150();
    stop_test();
  end

  // the run needs about 400 cycles; 25 times that means a hang
  initial begin
    cyc_n(10000);
    error_cnt++;
    stop_test();
  end
endmodule // ocp_guard_tb

// ---- ocp_pkg.sv ----
/*
  constants, field layouts, types and decode functions shared by the
  over-current protection block and its helpers.
  assumes a single 100 MHz clock and byte addressed wishbone registers.
*/
package ocp_pkg;

  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int CLK_MHZ = 100; // ref_clk rate
  localparam int LIM100_US = 50; // qualification time of the 100% limit
  localparam int LIM100_CYC = LIM100_US * CLK_MHZ; // cycles for 50 us
  localparam int MS_US = 1000; // microseconds in a millisecond
  localparam int MS_CYC = MS_US * CLK_MHZ; // cycles per millisecond
  localparam int TMR_W = 20; // wide enough for the 10 ms delay
  localparam int N_PHASE = 8; // monitored phases
  localparam int IMON_FS_MV = 2000; // monitor level at max system current
  localparam int ADC_MAX = 255; // full code of the 8-bit converter

  // --------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------
  localparam logic [7:0] ADR_PHASE_OCP = 8'h00; // per-phase setting
  localparam logic [7:0] ADR_FREQ = 8'h04; // switching frequency code
  localparam logic [7:0] ADR_IMON = 8'h08; // current monitor sample
  localparam logic [7:0] ADR_STATUS = 8'h0C; // sticky events
  localparam logic [7:0] ADR_MASK = 8'h10; // interrupt mask
  localparam logic [7:0] ADR_STATE = 8'h14; // live state

  // --------------------------------------------------------------
  // field positions and reset values
  // --------------------------------------------------------------
  localparam int OCP_OVR_BIT = 8; // override enable in ADR_PHASE_OCP
  localparam int IMON_MAX_BIT = 8; // sample at or above full scale
  localparam int EV_LIM100 = 0; // timed total limit trip
  localparam int EV_LIM150 = 1; // instant total limit trip
  localparam int EV_PHASE = 2; // per-phase latch-off
  localparam int EV_READY = 3; // lockout released, soft start allowed
  localparam int N_EV = 4;
  localparam logic [7:0] FREQ_RST = 8'h00;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [3:0] SEL_RST = 4'h0;

  // --------------------------------------------------------------
  // decode tables
  // --------------------------------------------------------------
  localparam logic [7:0] THR0_MV = 8'h41; // 65 mV
  localparam logic [7:0] THR1_MV = 8'h4B; // 75 mV
  localparam logic [7:0] THR2_MV = 8'h64; // 100 mV
  localparam logic [7:0] THR3_MV = 8'h86; // 134 mV
  localparam logic [3:0] DLY0_MS = 4'h4;
  localparam logic [3:0] DLY1_MS = 4'h6;
  localparam logic [3:0] DLY2_MS = 4'h8;
  localparam logic [3:0] DLY3_MS = 4'hA;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  // threshold index in the low bits so it steps fastest with the code
  typedef struct packed {
    logic [1:0] dly;
    logic [1:0] thr;
  } ocp_sel_type;

  typedef struct packed {
    logic enable;
    logic vcc_ok;
    logic ramp_ok;
    logic lim100;
    logic lim150;
    logic [N_PHASE-1:0] phase_over;
  } pins_type;

  typedef enum logic [3:0] {
    ST_UVLO = 4'h1,
    ST_SELECT = 4'h2,
    ST_RUN = 4'h4,
    ST_LATCHED = 4'h8
  } state_type;

  // threshold in mV for a two-bit index
  function automatic logic [7:0] thr_mv(input logic [1:0] idx);
    unique case (idx)
      2'h0: thr_mv = THR0_MV;
      2'h1: thr_mv = THR1_MV;
      2'h2: thr_mv = THR2_MV;
      2'h3: thr_mv = THR3_MV;
    endcase
  endfunction

  // latch-off delay in ms for a two-bit index
  function automatic logic [3:0] dly_ms(input logic [1:0] idx);
    unique case (idx)
      2'h0: dly_ms = DLY0_MS;
      2'h1: dly_ms = DLY1_MS;
      2'h2: dly_ms = DLY2_MS;
      2'h3: dly_ms = DLY3_MS;
    endcase
  endfunction

endpackage

// ---- sync3.sv ----
/*
  three flip-flop synchroniser with agreement filter.
  assumes asynchronous inputs; an output bit moves only when the second
  and third stages agree.
*/
module sync3 #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1_r; // first stage, read by s2_r only
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // ------------------------------------------------------------
  // stages; a bit that disagrees keeps its old output value
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      dout <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      dout <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & dout);
    end
  end

endmodule // sync3
